// *** rtl/ppm_params.svh ***
// constants for the programmable parallel port block
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// register bus addresses
`define PPM_ADDR_PORT_A 2'h0
`define PPM_ADDR_PORT_B 2'h1
`define PPM_ADDR_PORT_C 2'h2
`define PPM_ADDR_CTRL 2'h3

// control word fields
`define PPM_CW_MODE_FLAG 7
`define PPM_CW_GA_MODE_HI 6
`define PPM_CW_GA_MODE_LO 5
`define PPM_CW_A_DIR 4
`define PPM_CW_CU_DIR 3
`define PPM_CW_GB_MODE 2
`define PPM_CW_B_DIR 1
`define PPM_CW_CL_DIR 0
`define PPM_CW_BIT_HI 3
`define PPM_CW_BIT_LO 1
`define PPM_CW_BIT_VAL 0

// reset value of the control word: all inputs, mode 0
`define PPM_CW_RESET 8'h9b

// port c line positions used for handshaking
`define PPM_PC_IRQ_B 0
`define PPM_PC_FULL_B 1
`define PPM_PC_HS_B 2
`define PPM_PC_IRQ_A 3
`define PPM_PC_STB_A 4
`define PPM_PC_IBF_A 5
`define PPM_PC_ACK_A 6
`define PPM_PC_OBF_A 7

// group a mode encodings
`define PPM_MODE_0 2'h0
`define PPM_MODE_1 2'h1

`endif

// *** rtl/ppm_pkg.sv ***
// types shared by the programmable parallel port block
package ppm_pkg;
	// register bus request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ppm_bus_type;

	// one eight-bit port pin group
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} ppm_pins_type;

	// handshake engine states, gray from idle through busy to done
	typedef enum logic [1:0] {
		PPM_HS_IDLE = 2'b00,
		PPM_HS_BUSY = 2'b01,
		PPM_HS_DONE = 2'b11
	} ppm_hs_type;
endpackage

// *** rtl/ppm_sync.sv ***
// two-flop synchroniser with edge pulses
`timescale 1ns/100ps
module ppm_sync import ppm_pkg::*; #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout,
	output logic [WIDTH-1:0] fall,
	output logic [WIDTH-1:0] rise
);
	// ----------------------------------------
	// synchroniser stages
	// ----------------------------------------
	logic [WIDTH-1:0] meta_ff; // first stage, read only by second
	logic [WIDTH-1:0] stab_ff; // stable copy
	logic [WIDTH-1:0] prev_ff; // delayed copy for edges

	// per-bit stages
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					meta_ff[i] <= INIT[i];
					stab_ff[i] <= INIT[i];
					prev_ff[i] <= INIT[i];
				end else if (ce) begin
					meta_ff[i] <= din[i];
					stab_ff[i] <= meta_ff[i];
					prev_ff[i] <= stab_ff[i];
				end
			end
			assign fall[i] = prev_ff[i] & ~stab_ff[i];
			assign rise[i] = ~prev_ff[i] & stab_ff[i];
		end
	endgenerate

	assign dout = stab_ff;
endmodule

// *** rtl/ppm_port.sv ***
// three-port programmable parallel interface with strobed modes
//
// Operation
// - mode 0 direction bits per port group
// - mode 1: latched port plus three handshake lines
// - strobe low captures port input latch
// - input full set by strobe, cleared read end
// - input irq: strobe high, full, enabled
// - input irq enables: pc4 group a, pc2 b
// - output full on write end, cleared by ack
// - output irq: ack high, empty, enabled
// - output irq enables: pc6 group a, pc2 b
// - ports a, b independently input or output
// - mode 2 only group a, bidirectional
// - mode 2 drives port a only during ack
// - mode 2 irq ors both directions
// - mode 2 enables: pc6 out, pc4 in
// - writes precede ack, strobes precede read
// - unused input lines readable, upper by bitset only
// - unused lower outputs written directly or bitset
// - port c read returns status in modes 1 and 2
// - mode write clears outputs, flags, enables
// - reset: control word 9b (mode 0), all ports input
// - any port c bit set or cleared singly
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "ppm_params.svh"
module ppm_port import ppm_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [7:0] first_port_lines_in,
	output logic [7:0] first_port_lines_out,
	output logic [7:0] first_port_lines_oe,
	input wire logic [7:0] second_port_lines_in,
	output logic [7:0] second_port_lines_out,
	output logic [7:0] second_port_lines_oe,
	input wire logic [7:0] third_port_lines_in,
	output logic [7:0] third_port_lines_out,
	output logic [7:0] third_port_lines_oe
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	ppm_bus_type bus; // bundled request
	logic [7:0] cw_ff; // control word
	logic [7:0] pa_out_ff; // port a output latch
	logic [7:0] pb_out_ff; // port b output latch
	logic [7:0] pa_in_ff; // port a input latch
	logic [7:0] pb_in_ff; // port b input latch
	logic [7:0] pc_out_ff; // port c output latch
	logic [7:0] rdata_ff; // read data register
	logic ibf_a_ff; // group a input full
	logic ibf_b_ff; // group b input full
	logic obf_a_n_ff; // group a output full, low active
	logic obf_b_n_ff; // group b output full, low active
	logic irq_a_ff; // group a request
	logic irq_b_ff; // group b request
	ppm_hs_type hs_a_ff; // group a output transfer state
	logic [7:0] pa_s, pb_s, pc_s; // synchronised pins
	logic [7:0] pc_fall, pc_rise; // port c edges
	logic [7:0] pa_fall_unused, pa_rise_unused;
	logic [7:0] pb_fall_unused, pb_rise_unused;
	logic mode_wr, bsr_wr; // control write kinds
	logic [2:0] bsr_sel; // bit selected by bit set/reset
	logic wr_a, wr_b, wr_c; // port write strobes
	logic rd_a, rd_b; // port read strobes
	logic rd_a_q, rd_b_q, wr_a_q, wr_b_q; // delayed strobes, end edges
	logic [1:0] ga_mode; // group a mode
	logic gb_mode; // group b mode
	logic a_in, b_in, cu_in, cl_in; // direction bits
	logic a_hs, b_hs, a_m2; // handshake modes
	logic stb_a_n, stb_b_n, ack_a_n, ack_b_n; // handshake inputs
	logic irq_en_a_in, irq_en_a_out, irq_en_b; // enables in pc latch
	logic a_ibf_used, a_obf_used; // group a direction features
	logic [7:0] pc_hs_mask; // lines owned by handshaking
	logic [7:0] pc_hs_val; // handshake line values
	logic nxt_irq_a, nxt_irq_b;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	ppm_sync #(.WIDTH(8), .INIT(8'hff)) u_sync_c (.clk(clk), .nrst(nrst), .ce(ce),
		.din(third_port_lines_in), .dout(pc_s), .fall(pc_fall), .rise(pc_rise));
	ppm_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_a (.clk(clk), .nrst(nrst), .ce(ce),
		.din(first_port_lines_in), .dout(pa_s), .fall(pa_fall_unused),
		.rise(pa_rise_unused));
	ppm_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_b (.clk(clk), .nrst(nrst), .ce(ce),
		.din(second_port_lines_in), .dout(pb_s), .fall(pb_fall_unused),
		.rise(pb_rise_unused));

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign mode_wr = bus.wr && bus.addr == `PPM_ADDR_CTRL && bus.wdata[`PPM_CW_MODE_FLAG];
	assign bsr_wr = bus.wr && bus.addr == `PPM_ADDR_CTRL && !bus.wdata[`PPM_CW_MODE_FLAG];
	assign bsr_sel = bus.wdata[`PPM_CW_BIT_HI:`PPM_CW_BIT_LO];
	assign wr_a = bus.wr && bus.addr == `PPM_ADDR_PORT_A;
	assign wr_b = bus.wr && bus.addr == `PPM_ADDR_PORT_B;
	assign wr_c = bus.wr && bus.addr == `PPM_ADDR_PORT_C;
	assign rd_a = bus.rd && bus.addr == `PPM_ADDR_PORT_A;
	assign rd_b = bus.rd && bus.addr == `PPM_ADDR_PORT_B;

	// control word fields
	assign ga_mode = cw_ff[`PPM_CW_GA_MODE_HI:`PPM_CW_GA_MODE_LO];
	assign gb_mode = cw_ff[`PPM_CW_GB_MODE];
	assign a_in = cw_ff[`PPM_CW_A_DIR];
	assign cu_in = cw_ff[`PPM_CW_CU_DIR];
	assign b_in = cw_ff[`PPM_CW_B_DIR];
	assign cl_in = cw_ff[`PPM_CW_CL_DIR];
	assign a_m2 = ga_mode[1];
	assign a_hs = ga_mode == `PPM_MODE_1 || a_m2;
	assign b_hs = gb_mode;

	// handshake inputs from port c
	assign stb_a_n = pc_s[`PPM_PC_STB_A];
	assign ack_a_n = pc_s[`PPM_PC_ACK_A];
	assign stb_b_n = pc_s[`PPM_PC_HS_B];
	assign ack_b_n = pc_s[`PPM_PC_HS_B];
	assign a_ibf_used = a_m2 || a_in;
	assign a_obf_used = a_m2 || !a_in;

	// enables live in the port c latch, written by bit set/reset
	assign irq_en_a_in = pc_out_ff[`PPM_PC_STB_A];
	assign irq_en_a_out = pc_out_ff[`PPM_PC_ACK_A];
	assign irq_en_b = pc_out_ff[`PPM_PC_HS_B];

	// ----------------------------------------
	// control word
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cw_ff <= `PPM_CW_RESET;
		end else if (ce && mode_wr) begin
			cw_ff <= bus.wdata;
		end
	end

	// ----------------------------------------
	// port a and b output latches
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pa_out_ff <= 8'h00;
			pb_out_ff <= 8'h00;
		end else if (ce) begin
			if (mode_wr) begin
				pa_out_ff <= 8'h00;
				pb_out_ff <= 8'h00;
			end else begin
				if (wr_a) begin
					pa_out_ff <= bus.wdata;
				end
				if (wr_b) begin
					pb_out_ff <= bus.wdata;
				end
			end
		end
	end

	// ----------------------------------------
	// input latches, loaded while strobe low
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pa_in_ff <= 8'h00;
			pb_in_ff <= 8'h00;
		end else if (ce) begin
			if (a_hs && a_ibf_used && !stb_a_n) begin
				pa_in_ff <= pa_s;
			end
			if (b_hs && b_in && !stb_b_n) begin
				pb_in_ff <= pb_s;
			end
		end
	end

	// ----------------------------------------
	// port c output latch and interrupt enables
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc_out_ff <= 8'h00;
		end else if (ce) begin
			if (mode_wr) begin
				pc_out_ff <= 8'h00;
			end else if (bsr_wr) begin
				pc_out_ff[bsr_sel] <= bus.wdata[`PPM_CW_BIT_VAL];
			end else if (wr_c) begin
				pc_out_ff[3:0] <= bus.wdata[3:0];
				if (!a_hs) begin
					pc_out_ff[7:4] <= bus.wdata[7:4];
				end
			end
		end
	end

	// ----------------------------------------
	// delayed bus strobes; a one-cycle strobe ends one cycle later
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_a_q <= 1'b0;
			rd_b_q <= 1'b0;
			wr_a_q <= 1'b0;
			wr_b_q <= 1'b0;
		end else if (ce) begin
			rd_a_q <= rd_a;
			rd_b_q <= rd_b;
			wr_a_q <= wr_a;
			wr_b_q <= wr_b;
		end
	end

	// ----------------------------------------
	// input full flags: set wins over the read-end clear; a mode write clears first
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ibf_a_ff <= 1'b0;
			ibf_b_ff <= 1'b0;
		end else if (ce) begin
			if (mode_wr) begin
				ibf_a_ff <= 1'b0;
			end else if (a_hs && a_ibf_used && !stb_a_n) begin
				ibf_a_ff <= 1'b1;
			end else if (rd_a_q) begin
				ibf_a_ff <= 1'b0;
			end
			if (mode_wr) begin
				ibf_b_ff <= 1'b0;
			end else if (b_hs && b_in && !stb_b_n) begin
				ibf_b_ff <= 1'b1;
			end else if (rd_b_q) begin
				ibf_b_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// output full flags, low active; ack low clears
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			obf_a_n_ff <= 1'b1;
			obf_b_n_ff <= 1'b1;
		end else if (ce) begin
			if (mode_wr) begin
				obf_a_n_ff <= 1'b1;
			end else if (a_hs && a_obf_used && wr_a_q) begin
				obf_a_n_ff <= 1'b0;
			end else if (a_hs && a_obf_used && !ack_a_n) begin
				obf_a_n_ff <= 1'b1;
			end
			if (mode_wr) begin
				obf_b_n_ff <= 1'b1;
			end else if (b_hs && !b_in && wr_b_q) begin
				obf_b_n_ff <= 1'b0;
			end else if (b_hs && !b_in && !ack_b_n) begin
				obf_b_n_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// group a output transfer tracker, read by no other logic
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hs_a_ff <= PPM_HS_IDLE;
		end else if (ce) begin
			case (hs_a_ff)
				PPM_HS_IDLE: begin
					if (!ack_a_n) begin
						hs_a_ff <= PPM_HS_BUSY; // ack window open
					end
				end
				PPM_HS_BUSY: begin
					if (pc_rise[`PPM_PC_ACK_A]) begin
						hs_a_ff <= PPM_HS_DONE; // ack ended
					end
				end
				PPM_HS_DONE: begin
					hs_a_ff <= PPM_HS_IDLE;
				end
				default: begin
					hs_a_ff <= PPM_HS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// interrupt requests
	// ----------------------------------------
	always_comb begin
		// input and output sides of each group
		nxt_irq_a = 1'b0;
		nxt_irq_b = 1'b0;
		// the read and write end edges also hold the request down, so it
		// cannot rise again before the flag itself has changed
		if (a_hs && a_ibf_used && ibf_a_ff && irq_en_a_in && stb_a_n && !rd_a && !rd_a_q) begin
			nxt_irq_a = 1'b1;
		end
		if (a_hs && a_obf_used && obf_a_n_ff && irq_en_a_out && ack_a_n && !wr_a && !wr_a_q
			&& (a_m2 || !a_in)) begin
			nxt_irq_a = 1'b1;
		end
		if (b_hs && b_in && ibf_b_ff && irq_en_b && stb_b_n && !rd_b && !rd_b_q) begin
			nxt_irq_b = 1'b1;
		end
		if (b_hs && !b_in && obf_b_n_ff && irq_en_b && ack_b_n && !wr_b && !wr_b_q) begin
			nxt_irq_b = 1'b1;
		end
	end

	// request flops; the rising read or write strobe drops them
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_a_ff <= 1'b0;
			irq_b_ff <= 1'b0;
		end else if (ce) begin
			irq_a_ff <= nxt_irq_a && !mode_wr;
			irq_b_ff <= nxt_irq_b && !mode_wr;
		end
	end

	// ----------------------------------------
	// port c line values owned by handshaking
	// ----------------------------------------
	always_comb begin
		// defaults: no handshake lines
		pc_hs_mask = 8'h00;
		pc_hs_val = 8'h00;
		if (b_hs) begin
			pc_hs_mask[`PPM_PC_IRQ_B] = 1'b1;
			pc_hs_val[`PPM_PC_IRQ_B] = irq_b_ff;
			pc_hs_mask[`PPM_PC_FULL_B] = 1'b1;
			pc_hs_val[`PPM_PC_FULL_B] = b_in ? ibf_b_ff : obf_b_n_ff;
			pc_hs_val[`PPM_PC_HS_B] = pc_s[`PPM_PC_HS_B];
			pc_hs_mask[`PPM_PC_HS_B] = 1'b1;
		end
		if (a_hs) begin
			pc_hs_mask[`PPM_PC_IRQ_A] = 1'b1;
			pc_hs_val[`PPM_PC_IRQ_A] = irq_a_ff;
			if (a_ibf_used) begin
				pc_hs_mask[`PPM_PC_STB_A] = 1'b1;
				pc_hs_val[`PPM_PC_STB_A] = pc_s[`PPM_PC_STB_A];
				pc_hs_mask[`PPM_PC_IBF_A] = 1'b1;
				pc_hs_val[`PPM_PC_IBF_A] = ibf_a_ff;
			end
			if (a_obf_used) begin
				pc_hs_mask[`PPM_PC_ACK_A] = 1'b1;
				pc_hs_val[`PPM_PC_ACK_A] = pc_s[`PPM_PC_ACK_A];
				pc_hs_mask[`PPM_PC_OBF_A] = 1'b1;
				pc_hs_val[`PPM_PC_OBF_A] = obf_a_n_ff;
			end
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	assign first_port_lines_out = pa_out_ff;
	// mode 2 drives only during ack; mode 0/1 by direction bit
	assign first_port_lines_oe = a_m2 ? {8{!ack_a_n}} : {8{!a_in}};
	assign second_port_lines_out = pb_out_ff;
	assign second_port_lines_oe = {8{!b_in}};
	assign third_port_lines_out = (pc_out_ff & ~pc_hs_mask) | (pc_hs_val & pc_hs_mask);
	// handshake outputs: irq and full flags; inputs strobe/ack never driven
	assign third_port_lines_oe = ({{4{!cu_in}}, {4{!cl_in}}} & ~pc_hs_mask)
		| (pc_hs_mask & 8'b1010_1011 & ~{1'b0, {3{1'b0}}, 4'h0}
		& {a_obf_used, 1'b0, a_ibf_used, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1});

	// ----------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
		end else if (ce) begin
			if (bus.rd) begin
				case (bus.addr)
					`PPM_ADDR_PORT_A: begin
						rdata_ff <= (a_hs && a_ibf_used) ? pa_in_ff : (a_in ? pa_s : pa_out_ff);
					end
					`PPM_ADDR_PORT_B: begin
						rdata_ff <= (b_hs && b_in) ? pb_in_ff : (b_in ? pb_s : pb_out_ff);
					end
					`PPM_ADDR_PORT_C: begin
						// status lines, then input pins, then latch
						rdata_ff <= (pc_hs_val & pc_hs_mask) | (~pc_hs_mask
							& (({{4{cu_in}}, {4{cl_in}}} & pc_s)
							| ({{4{!cu_in}}, {4{!cl_in}}} & pc_out_ff)));
					end
					default: begin
						rdata_ff <= 8'h00; // control word is write only
					end
				endcase
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	assign rdata = rdata_ff;
endmodule

// *** verif/ppm_port_chk.sv ***
// concurrent checks on the parallel port block pins and bus
`timescale 1ns/100ps
`include "ppm_params.svh"
module ppm_port_chk import ppm_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [7:0] first_port_lines_in,
	input wire logic [7:0] first_port_lines_out,
	input wire logic [7:0] first_port_lines_oe,
	input wire logic [7:0] second_port_lines_in,
	input wire logic [7:0] second_port_lines_out,
	input wire logic [7:0] second_port_lines_oe,
	input wire logic [7:0] third_port_lines_in,
	input wire logic [7:0] third_port_lines_out,
	input wire logic [7:0] third_port_lines_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// shadow of the last mode word, so checks know the configuration
	logic [7:0] cw_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cw_ff <= `PPM_CW_RESET;
		end else if (ce && wr && addr == `PPM_ADDR_CTRL && wdata[7]) begin
			cw_ff <= wdata;
		end
	end
	wire in_a = cw_ff[6:5] == 2'h1 && cw_ff[4]; // group a strobed input
	wire out_a = cw_ff[6:5] == 2'h1 && !cw_ff[4]; // group a strobed output
	property p_rdata_idle;
		!$past(rd) |-> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_ctrl_read;
		rd && addr == `PPM_ADDR_CTRL |=> rdata == 8'h00;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read not zero");
	property p_dir_a;
		cw_ff == $past(cw_ff) && cw_ff[6:5] == 2'h0 |-> first_port_lines_oe == {8{!cw_ff[4]}};
	endproperty
	a_dir_a: assert property (p_dir_a) else $error("port a direction wrong");
	property p_dir_bc;
		cw_ff == $past(cw_ff) && cw_ff[6:5] == 2'h0 && !cw_ff[2] |->
			{second_port_lines_oe, third_port_lines_oe} ==
			{{8{!cw_ff[1]}}, {4{!cw_ff[3]}}, {4{!cw_ff[0]}}};
	endproperty
	a_dir_bc: assert property (p_dir_bc) else $error("port b or c direction wrong");
	property p_bidir_drive;
		(cw_ff[6] && !third_port_lines_in[6])[*5] |-> first_port_lines_oe == 8'hff;
	endproperty
	a_bidir_drive: assert property (p_bidir_drive) else $error("port a not driven");
	property p_bidir_hiz;
		(cw_ff[6] && third_port_lines_in[6])[*5] |-> first_port_lines_oe == 8'h00;
	endproperty
	a_bidir_hiz: assert property (p_bidir_hiz) else $error("port a driven");
	property p_ibf_set;
		in_a && $fell(third_port_lines_in[4]) |-> ##[2:4] third_port_lines_out[5];
	endproperty
	a_ibf_set: assert property (p_ibf_set) else $error("input full not set");
	property p_obf_set;
		out_a && wr && addr == `PPM_ADDR_PORT_A |-> ##[1:3] !third_port_lines_out[7];
	endproperty
	a_obf_set: assert property (p_obf_set) else $error("output full not flagged");
	property p_irq_drop;
		in_a && rd && addr == `PPM_ADDR_PORT_A |-> ##[1:3] !third_port_lines_out[3];
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq not dropped on read");
endmodule
bind ppm_port ppm_port_chk u_chk (.clk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata,
	.first_port_lines_in, .first_port_lines_out, .first_port_lines_oe,
	.second_port_lines_in, .second_port_lines_out, .second_port_lines_oe,
	.third_port_lines_in, .third_port_lines_out, .third_port_lines_oe);

// *** verif/ppm_peer.sv ***
// peripheral model at the far side of the three ports
`timescale 1ns/100ps
module ppm_peer (
	input wire logic clk,
	input wire logic [7:0] pa_out,
	input wire logic [7:0] pa_oe,
	input wire logic [7:0] pb_out,
	input wire logic [7:0] pb_oe,
	input wire logic [7:0] pc_out,
	input wire logic [7:0] pc_oe,
	output logic [7:0] pa_in,
	output logic [7:0] pb_in,
	output logic [7:0] pc_in
);
	logic [7:0] pa_v = 8'h5a; // level on port a where the device lets go
	logic [7:0] pb_v = 8'ha5;
	logic [7:0] pc_v = 8'hff; // strobe and ack idle high
	logic [7:0] got_a = 8'h00; // byte seen during the last ack
	logic ack_en = 1'h0;
	int ack_dly = 0; // cycles before answering a full flag
	int got_n = 0;
	// wire level: the device wins on every line it drives
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_v);
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_v);
	assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_v);
	// strobe a byte in, then let the data lines drift after the hold
	task automatic strobe(input logic [7:0] d);
		@(posedge clk);
		pa_v <= d;
		pc_v[4] <= 1'h0;
		repeat (4) @(posedge clk);
		pc_v[4] <= 1'h1;
		repeat (2) @(posedge clk);
		pa_v <= ~d;
	endtask
	// acknowledge only after the device has flagged a written byte
	always @(posedge clk) begin
		if (ack_en && pc_oe[7] && !pc_out[7]) begin
			repeat (ack_dly) @(posedge clk);
			pc_v[6] <= 1'h0;
			repeat (6) @(posedge clk);
			got_a <= pa_in;
			got_n <= got_n + 1;
			pc_v[6] <= 1'h1;
		end
	end
endmodule

// *** verif/tb_ppm_port.sv ***
// self-checking bench for the parallel port block
`timescale 1ns/100ps
`include "ppm_params.svh"
module tb_ppm_port import ppm_pkg::*;;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic ce = 1'h1; // held high: clock enable freezing is not exercised
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [7:0] rdata, first_port_lines_in, first_port_lines_out, first_port_lines_oe;
	logic [7:0] second_port_lines_in, second_port_lines_out, second_port_lines_oe;
	logic [7:0] third_port_lines_in, third_port_lines_out, third_port_lines_oe;
	int num_errors = 0;
	int checks_done = 0;
	int n;
	always #50 clk = ~clk;
	ppm_port dut (.clk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata,
		.first_port_lines_in, .first_port_lines_out, .first_port_lines_oe,
		.second_port_lines_in, .second_port_lines_out, .second_port_lines_oe,
		.third_port_lines_in, .third_port_lines_out, .third_port_lines_oe);
	ppm_peer peer (.clk, .pa_out(first_port_lines_out), .pa_oe(first_port_lines_oe),
		.pb_out(second_port_lines_out), .pb_oe(second_port_lines_oe),
		.pc_out(third_port_lines_out), .pc_oe(third_port_lines_oe),
		.pa_in(first_port_lines_in), .pb_in(second_port_lines_in),
		.pc_in(third_port_lines_in));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	// read one register and compare the masked byte
	task automatic rdchk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		chk(rdata & m, e);
	endtask
	// bounded wait for the peer to take one more byte
	task automatic wait_ack(input int n0);
		for (int i = 0; i < 200 && peer.got_n == n0; i++) @(posedge clk);
		@(negedge clk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		tick(1);
		chk(first_port_lines_oe | second_port_lines_oe | third_port_lines_oe, 8'h00);
		rdchk(`PPM_ADDR_PORT_A, 8'hff, 8'h5a);
		rdchk(`PPM_ADDR_PORT_B, 8'hff, 8'ha5);
		rdchk(`PPM_ADDR_CTRL, 8'hff, 8'h00);
	endtask
	task automatic t_mode0;
		for (int k = 0; k < 16; k++) begin
			bus_wr(`PPM_ADDR_CTRL, {3'h4, k[3], k[2], 1'h0, k[1], k[0]});
			tick(2);
			chk(first_port_lines_oe, {8{~k[3]}});
			chk(second_port_lines_oe, {8{~k[1]}});
			chk(third_port_lines_oe, {{4{~k[2]}}, {4{~k[0]}}});
		end
	endtask
	task automatic t_bsr;
		bus_wr(`PPM_ADDR_CTRL, 8'h80);
		bus_wr(`PPM_ADDR_PORT_A, 8'h3c);
		bus_wr(`PPM_ADDR_PORT_B, 8'hc3);
		bus_wr(`PPM_ADDR_PORT_C, 8'h5a);
		tick(2);
		chk(first_port_lines_out, 8'h3c);
		chk(second_port_lines_out, 8'hc3);
		chk(third_port_lines_out, 8'h5a);
		for (int i = 0; i < 8; i++) bus_wr(`PPM_ADDR_CTRL, {4'h0, i[2:0], 1'h1});
		tick(2);
		chk(third_port_lines_out, 8'hff);
		for (int i = 0; i < 8; i += 2) bus_wr(`PPM_ADDR_CTRL, {4'h0, i[2:0], 1'h0});
		tick(2);
		chk(third_port_lines_out, 8'haa);
		bus_wr(`PPM_ADDR_CTRL, 8'ha0); // group a strobed output, group b plain
		bus_wr(`PPM_ADDR_PORT_C, 8'hff);
		tick(2);
		chk(third_port_lines_out & 8'h37, 8'h07);
		bus_wr(`PPM_ADDR_CTRL, 8'h0b);
		tick(2);
		chk(third_port_lines_out & 8'h37, 8'h27);
	endtask
	task automatic t_strobe_in;
		bus_wr(`PPM_ADDR_CTRL, 8'hb0);
		peer.strobe(8'ha5);
		tick(3);
		rdchk(`PPM_ADDR_PORT_C, 8'h28, 8'h20);
		rdchk(`PPM_ADDR_PORT_A, 8'hff, 8'ha5);
		tick(3);
		rdchk(`PPM_ADDR_PORT_C, 8'h28, 8'h00);
		bus_wr(`PPM_ADDR_CTRL, 8'h09);
		peer.strobe(8'h96);
		tick(3);
		rdchk(`PPM_ADDR_PORT_C, 8'h28, 8'h28);
		rdchk(`PPM_ADDR_PORT_A, 8'hff, 8'h96);
		tick(3);
		rdchk(`PPM_ADDR_PORT_C, 8'h28, 8'h00);
	endtask
	task automatic t_strobe_out;
		bus_wr(`PPM_ADDR_CTRL, 8'ha0);
		bus_wr(`PPM_ADDR_CTRL, 8'h0d);
		peer.ack_en = 1'h1;
		n = peer.got_n;
		bus_wr(`PPM_ADDR_PORT_A, 8'h3c);
		wait_ack(n);
		chk(peer.got_a, 8'h3c);
		tick(3);
		rdchk(`PPM_ADDR_PORT_C, 8'h88, 8'h88);
		peer.ack_dly = 6;
		n = peer.got_n;
		bus_wr(`PPM_ADDR_PORT_A, 8'hc3);
		rdchk(`PPM_ADDR_PORT_C, 8'h88, 8'h00);
		wait_ack(n);
		chk(peer.got_a, 8'hc3);
	endtask
	task automatic t_mode2;
		bus_wr(`PPM_ADDR_CTRL, 8'hc0);
		bus_wr(`PPM_ADDR_CTRL, 8'h0d);
		bus_wr(`PPM_ADDR_CTRL, 8'h09);
		tick(1);
		chk(first_port_lines_oe, 8'h00);
		n = peer.got_n;
		bus_wr(`PPM_ADDR_PORT_A, 8'h69);
		wait_ack(n);
		chk(peer.got_a, 8'h69);
		peer.strobe(8'h17);
		tick(3);
		rdchk(`PPM_ADDR_PORT_C, 8'ha8, 8'ha8);
		rdchk(`PPM_ADDR_PORT_A, 8'hff, 8'h17);
		tick(3);
		rdchk(`PPM_ADDR_PORT_C, 8'ha8, 8'h88);
		bus_wr(`PPM_ADDR_CTRL, 8'hc0);
		tick(2);
		rdchk(`PPM_ADDR_PORT_C, 8'h08, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		t_reset();
		t_mode0();
		t_bsr();
		t_strobe_in();
		t_strobe_out();
		t_mode2();
		results();
	end
	// watchdog well beyond the roughly three hundred cycles the scenarios need
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule
